// file: common/bem_pkg.sv
// package: register map, field positions, codes and states of the mode-control block
package bem_pkg;
	localparam logic [7:0]  OFS_ENABLE = 8'h00;
	localparam logic [7:0]  OFS_CMD    = 8'h04;
	localparam logic [7:0]  OFS_STATUS = 8'h08;
	localparam logic [7:0]  OFS_ADDR   = 8'h0C;
	localparam logic [7:0]  OFS_BLEN   = 8'h10;
	localparam logic [7:0]  ENABLE_RST = 8'h00;
	localparam int          PAGE_W     = 11;
	localparam logic [10:0] ADDR_RST   = 11'h000;
	localparam logic [10:0] BLEN_RST   = 11'h001;
	localparam logic [10:0] PAGE_ONE   = 11'h001;
	// enable byte fields
	localparam int EN_NORMAL = 0;
	localparam int EN_PARITY = 1;
	localparam int EN_ERRINT = 2;
	localparam int EN_DMA    = 3;
	localparam int EN_RATE   = 4;
	localparam int EN_HALT   = 5;
	localparam int EN_AUTO   = 6;
	// status byte fields
	localparam int ST_FIFO = 0;
	localparam int ST_PAR  = 1;
	localparam int ST_CE   = 2;
	localparam int ST_UCE  = 3;
	localparam int ST_TE   = 4;
	localparam int ST_FAIL = 5;
	localparam int ST_DONE = 6;
	localparam int ST_BUSY = 7;
	// command codes
	localparam logic [3:0] CMD_INIT  = 4'h1;
	localparam logic [3:0] CMD_READ  = 4'h2;
	localparam logic [3:0] CMD_WRITE = 4'h3;
	localparam logic [3:0] CMD_ABORT = 4'h9;
	localparam logic [3:0] CMD_RCORR = 4'hC;
	// transfer modes
	localparam logic [1:0] XFER_POLL = 2'h0;
	localparam logic [1:0] XFER_INT  = 2'h1;
	localparam logic [1:0] XFER_DMA  = 2'h2;
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_RUN  = 4'h2,
		S_HALT = 4'h4,
		S_FIX  = 4'h8
	} bem_state_t;
endpackage

// file: rtl/bem_rst_sync.sv
// reset release synchroniser
`timescale 1ns/100ps
`default_nettype none
module bem_rst_sync (
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	output logic      o_rst_n
);
	logic meta_r;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r  <= 1'b0;
			o_rst_n <= 1'b0;
		end else begin
			meta_r  <= 1'b1;
			o_rst_n <= meta_r;
		end
	end
endmodule
`default_nettype wire

// file: rtl/bem_err_gate.sv
// error-cause gating by correction mode and error-interrupt bit
`timescale 1ns/100ps
`default_nettype none
module bem_err_gate (
	input  wire logic i_auto,
	input  wire logic i_halt,
	input  wire logic i_errint,
	input  wire logic i_ce,
	input  wire logic i_uce,
	input  wire logic i_te,
	output logic      o_hit
);
	always_comb begin
		case ({i_halt, i_auto})
			2'b00: o_hit = i_errint & i_te; // [R08] [R09]
			2'b01,
			2'b10: o_hit = i_uce | i_te | (i_errint & i_ce); // [R10] [R11]
			default: o_hit = 1'b0; // both modes on is an unused setting
		endcase
	end
endmodule
`default_nettype wire

// file: rtl/bem_mode_ctrl.sv
// mode control, error gating and interrupt merge of a bubble memory controller
// How it works
// [R01] transfer mode polled, interrupt or DMA follows the enable byte
// [R02] host must initialise after changing correction mode before it applies
// [R03] normal-interrupt and read-rate bits act live, no initialise needed
// [R04] completion, parity and formatter errors each selectable, merged onto one line
// [R05] host reads status to learn the interrupt cause
// [R06] FIFO half-full goes to the transfer request pin, ungated
// [R07] error-interrupt bit is enable bit 2, combined with both mode bits
// [R08] no correction, error bit clear: no error interrupts
// [R09] no correction, error bit set: timing errors only
// [R10] one mode: uncorrectable or timing, plus corrected when error bit set
// [R11] a correction mode alone enables error interrupts
// [R12] auto mode commands formatter to correct and forward correctable pages
// [R13] auto mode corrected error only reported in status without error bit
// [R14] host retries uncorrectable page by reissuing read unchanged
// [R15] auto mode passes uncorrectable page to FIFO before interrupting
// [R16] halt mode fixes correctable errors, stops on uncorrectable or timing
// [R17] halt mode with error bit stops on any error
// [R18] halt stop keeps bad page in formatter, not moved to FIFO
// [R19] command 0CH corrects held page and moves it into the FIFO
// [R20] address advances only after a good page, so it names a failed page
// [R21] commands other than abort accepted only while not busy
// [R22] host leaves parametric registers alone until the operation ends
// [R23] interrupt is the OR of every enabled condition
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bem_mode_ctrl (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_parity_err,
	input  wire logic        i_fifo_avail,
	input  wire logic        i_fifo_half_full,
	input  wire logic        i_fmt_page_done,
	input  wire logic        i_fmt_ce,
	input  wire logic        i_fmt_uce,
	input  wire logic        i_fmt_te,
	input  wire logic        i_fmt_fix_done,
	output logic             o_fmt_start,
	output logic             o_fmt_correct,
	output logic             o_fmt_xfer,
	output logic             o_fmt_stop,
	output logic [1:0]       o_xfer_mode,
	output logic             o_read_rate_select,
	output logic             o_transfer_request_pin,
	output logic             o_irq
);
	logic                rst_n;
	bem_pkg::bem_state_t state_r;
	logic [7:0]          enable_r;
	logic [6:1]          sts_r;
	logic [6:1]          sts_set;
	logic [10:0]         addr_r;
	logic [10:0]         blen_r;
	logic [10:0]         cnt_r;
	logic                auto_q_r;
	logic                halt_q_r;
	logic                acc;
	logic                wr;
	logic                cmd_wr;
	logic                cmd_ok;
	logic [3:0]          code;
	logic                busy;
	logic                page_hit;
	logic                sts_hit;
	logic                pg_good;
	logic                pg_halt;
	logic                pg_fail;
	logic                pg_last;
	logic [7:0]          status;

	bem_rst_sync u_rst (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.o_rst_n  (rst_n)
	);

	// apb access phase completes on the cycle pready is high
	assign acc    = i_psel & i_penable & o_pready;
	assign wr     = acc & i_pwrite;
	assign code   = i_pwdata[3:0];
	assign cmd_wr = wr & (i_paddr == bem_pkg::OFS_CMD);
	assign busy   = (state_r == bem_pkg::S_RUN) | (state_r == bem_pkg::S_FIX);
	assign cmd_ok = cmd_wr & (!busy | (code == bem_pkg::CMD_ABORT)); // [R21]
	assign status = {busy, sts_r, i_fifo_avail};

	// stop decision for the page just finished, on latched modes
	bem_err_gate u_page_gate (
		.i_auto   (auto_q_r),
		.i_halt   (halt_q_r),
		.i_errint (enable_r[bem_pkg::EN_ERRINT]),
		.i_ce     (i_fmt_ce),
		.i_uce    (i_fmt_uce),
		.i_te     (i_fmt_te),
		.o_hit    (page_hit)
	);

	// interrupt cause from the sticky status bits
	bem_err_gate u_sts_gate (
		.i_auto   (auto_q_r),
		.i_halt   (halt_q_r),
		.i_errint (enable_r[bem_pkg::EN_ERRINT]), // [R07]
		.i_ce     (sts_r[bem_pkg::ST_CE]),
		.i_uce    (sts_r[bem_pkg::ST_UCE]),
		.i_te     (sts_r[bem_pkg::ST_TE]),
		.o_hit    (sts_hit)
	);

	// classify a finished page while running
	always_comb begin
		pg_halt = 1'b0;
		pg_fail = 1'b0;
		pg_good = 1'b0;
		pg_last = (cnt_r == bem_pkg::PAGE_ONE);
		if ((state_r == bem_pkg::S_RUN) && i_fmt_page_done) begin
			if (halt_q_r && page_hit) begin
				pg_halt = 1'b1; // [R16] [R17]
			end else if ((auto_q_r && i_fmt_uce) || i_fmt_te) begin
				pg_fail = 1'b1;
			end else begin
				pg_good = 1'b1;
			end
		end
	end

	// apb slave: one wait state, so every answer comes from a flop
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & i_penable & !o_pready;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			if (i_psel && i_penable && !o_pready) begin
				case (i_paddr)
					bem_pkg::OFS_ENABLE: o_prdata <= {24'h00_0000, enable_r};
					bem_pkg::OFS_CMD,
					bem_pkg::OFS_STATUS: o_prdata <= {24'h00_0000, status};
					bem_pkg::OFS_ADDR:   o_prdata <= {21'h00_0000, addr_r};
					bem_pkg::OFS_BLEN:   o_prdata <= {21'h00_0000, blen_r};
					default:             o_pslverr <= 1'b1;
				endcase
			end
		end
	end

	// enable byte is live; host keeps it still during operations
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= bem_pkg::ENABLE_RST;
			blen_r   <= bem_pkg::BLEN_RST;
		end else begin
			if (wr && (i_paddr == bem_pkg::OFS_ENABLE)) begin
				enable_r <= i_pwdata[7:0]; // [R03]
			end
			if (wr && (i_paddr == bem_pkg::OFS_BLEN)) begin
				blen_r <= i_pwdata[10:0];
			end
		end
	end

	// correction modes take effect only at initialise
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_q_r <= 1'b0;
			halt_q_r <= 1'b0;
		end else if (cmd_ok && (code == bem_pkg::CMD_INIT)) begin
			auto_q_r <= enable_r[bem_pkg::EN_AUTO]; // [R02]
			halt_q_r <= enable_r[bem_pkg::EN_HALT];
		end
	end

	// operation sequencer and formatter commands
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r       <= bem_pkg::S_IDLE;
			addr_r        <= bem_pkg::ADDR_RST;
			cnt_r         <= bem_pkg::BLEN_RST;
			o_fmt_start   <= 1'b0;
			o_fmt_correct <= 1'b0;
			o_fmt_xfer    <= 1'b0;
			o_fmt_stop    <= 1'b0;
		end else begin
			o_fmt_start   <= 1'b0;
			o_fmt_correct <= 1'b0;
			o_fmt_xfer    <= 1'b0;
			o_fmt_stop    <= 1'b0;
			if (wr && (i_paddr == bem_pkg::OFS_ADDR)) begin
				addr_r <= i_pwdata[10:0];
			end
			if (cmd_ok) begin
				case (code)
					bem_pkg::CMD_ABORT: begin
						state_r    <= bem_pkg::S_IDLE; // [R21]
						o_fmt_stop <= 1'b1;
					end
					bem_pkg::CMD_READ,
					bem_pkg::CMD_WRITE: begin
						state_r     <= bem_pkg::S_RUN;
						cnt_r       <= blen_r;
						o_fmt_start <= 1'b1;
					end
					bem_pkg::CMD_RCORR: begin
						if (state_r == bem_pkg::S_HALT) begin
							state_r       <= bem_pkg::S_FIX; // [R19]
							o_fmt_correct <= 1'b1;
							o_fmt_xfer    <= 1'b1;
						end
					end
					default: begin
						state_r <= bem_pkg::S_IDLE;
					end
				endcase
			end else begin
				case (state_r)
					bem_pkg::S_RUN: begin
						if (pg_halt) begin
							state_r <= bem_pkg::S_HALT; // [R18]
						end else if (pg_fail) begin
							o_fmt_xfer <= auto_q_r & i_fmt_uce & !i_fmt_te; // [R15]
							state_r    <= bem_pkg::S_IDLE;
						end else if (pg_good) begin
							// correctable pages are repaired on the fly in either mode
							o_fmt_correct <= i_fmt_ce & (auto_q_r | halt_q_r); // [R12] [R16]
							o_fmt_xfer    <= 1'b1;
							addr_r        <= addr_r + bem_pkg::PAGE_ONE; // [R20]
							cnt_r         <= cnt_r - bem_pkg::PAGE_ONE;
							if (pg_last) begin
								state_r <= bem_pkg::S_IDLE;
							end
						end
					end
					bem_pkg::S_FIX: begin
						if (i_fmt_fix_done) begin
							state_r <= bem_pkg::S_IDLE;
						end
					end
					bem_pkg::S_IDLE,
					bem_pkg::S_HALT: begin
						state_r <= state_r;
					end
					default: begin
						state_r <= bem_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// sticky status: a new command clears it, a same-cycle event still lands
	always_comb begin
		sts_set                  = '0;
		sts_set[bem_pkg::ST_PAR] = i_parity_err;
		if ((state_r == bem_pkg::S_RUN) && i_fmt_page_done) begin
			sts_set[bem_pkg::ST_CE]  = i_fmt_ce; // [R13]
			sts_set[bem_pkg::ST_UCE] = i_fmt_uce;
			sts_set[bem_pkg::ST_TE]  = i_fmt_te;
		end
		sts_set[bem_pkg::ST_FAIL] = pg_halt | pg_fail;
		sts_set[bem_pkg::ST_DONE] = (pg_good & pg_last) | ((state_r == bem_pkg::S_FIX) & i_fmt_fix_done)
			| (cmd_ok & (code == bem_pkg::CMD_INIT));
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_r <= '0;
		end else begin
			sts_r <= (cmd_ok ? 6'h00 : sts_r) | sts_set;
		end
	end

	// pins facing the host
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_irq                  <= 1'b0;
			o_xfer_mode            <= bem_pkg::XFER_POLL;
			o_read_rate_select     <= 1'b0;
			o_transfer_request_pin <= 1'b0;
		end else begin
			o_irq <= (enable_r[bem_pkg::EN_NORMAL] & sts_r[bem_pkg::ST_DONE])
				| (enable_r[bem_pkg::EN_PARITY] & sts_r[bem_pkg::ST_PAR])
				| sts_hit; // [R04] [R23]
			if (enable_r[bem_pkg::EN_DMA]) begin
				o_xfer_mode <= bem_pkg::XFER_DMA; // [R01]
			end else if (|enable_r[2:0] || auto_q_r || halt_q_r) begin
				o_xfer_mode <= bem_pkg::XFER_INT;
			end else begin
				o_xfer_mode <= bem_pkg::XFER_POLL;
			end
			o_read_rate_select     <= enable_r[bem_pkg::EN_RATE]; // [R03]
			o_transfer_request_pin <= i_fifo_half_full; // [R06]
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	sequence s_fix_cmd;
		(state_r == bem_pkg::S_HALT) && cmd_wr && (code == bem_pkg::CMD_RCORR);
	endsequence
	sequence s_fix_out;
		o_fmt_correct && o_fmt_xfer && (state_r == bem_pkg::S_FIX);
	endsequence

	a_busy_refuse: assert property ( // [R21]
		cmd_wr && busy && (code != bem_pkg::CMD_ABORT) |=> !o_fmt_start && !o_fmt_stop)
		else $error("command accepted while busy");
	a_abort_any: assert property ( // [R21]
		cmd_wr && (code == bem_pkg::CMD_ABORT) |=> (state_r == bem_pkg::S_IDLE) && o_fmt_stop)
		else $error("abort not taken");
	a_fix_order: assert property (s_fix_cmd |=> s_fix_out) // [R19]
		else $error("correct command did not fix held page");
	a_halt_hold: assert property ( // [R18]
		pg_halt && !cmd_wr |=> (state_r == bem_pkg::S_HALT) && !o_fmt_xfer && $stable(addr_r))
		else $error("halted page left the formatter");
	a_auto_uce: assert property ( // [R15]
		pg_fail && auto_q_r && i_fmt_uce && !i_fmt_te && !cmd_wr |=> o_fmt_xfer ##1 sts_r[bem_pkg::ST_FAIL])
		else $error("uncorrectable page not passed to fifo");
	a_addr_fail: assert property ( // [R20]
		(pg_halt || pg_fail) && !wr |=> $stable(addr_r))
		else $error("address advanced on a failed page");
	a_drq_pass: assert property ( // [R06]
		##1 o_transfer_request_pin == $past(i_fifo_half_full))
		else $error("transfer request pin does not follow half full");
	a_no_err_irq: assert property ( // [R08]
		!auto_q_r && !halt_q_r && (enable_r[2:0] == 3'h0) |=> !o_irq)
		else $error("error raised interrupt with errors disabled");
	a_te_only: assert property ( // [R09]
		!auto_q_r && !halt_q_r && (enable_r[2:0] == 3'h4) && !sts_r[bem_pkg::ST_TE] |=> !o_irq)
		else $error("non-timing error raised interrupt");
	a_ecc_irq: assert property ( // [R11]
		(auto_q_r ^ halt_q_r) && sts_r[bem_pkg::ST_UCE] |=> o_irq)
		else $error("correction mode did not enable error interrupt");
	a_mode_init: assert property ( // [R02]
		$changed(halt_q_r) || $changed(auto_q_r) |-> $past(cmd_ok) && ($past(code) == bem_pkg::CMD_INIT))
		else $error("correction mode changed without initialise");
endmodule
`default_nettype wire

// file: tb/bem_fmt_model.sv
// formatter unit model: page completions, error flags, correction handshake
`timescale 1ns/100ps
`default_nettype none
module bem_fmt_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_start,
	input  wire logic       i_correct,
	input  wire logic       i_stop,
	input  wire logic [3:0] i_pages,
	input  wire logic [2:0] i_flags,
	input  wire logic [7:0] i_gap,
	output logic            o_page_done,
	output logic            o_ce,
	output logic            o_uce,
	output logic            o_te,
	output logic            o_fix_done
);
	logic [3:0] left_r;
	logic [7:0] cnt_r;
	logic [7:0] fix_r;
	logic [2:0] flg_r;
	logic       tog_r;
	// flags mean nothing without the page strobe, so they keep moving
	assign o_ce  = o_page_done ? flg_r[0] : tog_r;
	assign o_uce = o_page_done ? flg_r[1] : ~tog_r;
	assign o_te  = o_page_done ? flg_r[2] : tog_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			left_r <= 4'h0;
			cnt_r <= 8'h00;
			fix_r <= 8'h00;
			flg_r <= 3'h0;
			tog_r <= 1'b0;
			o_page_done <= 1'b0;
			o_fix_done <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
			o_page_done <= 1'b0;
			o_fix_done <= 1'b0;
			if (i_stop) begin
				left_r <= 4'h0;
			end else if (i_start) begin
				left_r <= i_pages;
				cnt_r <= i_gap;
			end else if (left_r != 4'h0) begin
				if (cnt_r == 8'h00) begin
					o_page_done <= 1'b1;
					// only the first page of a block carries errors
					flg_r <= (left_r == i_pages) ? i_flags : 3'h0;
					left_r <= left_r - 4'h1;
					cnt_r <= i_gap;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end
			// each correct request restarts the countdown, so requests close together share one answer; extras are the design's to ignore
			if (i_correct) begin
				fix_r <= i_gap + 8'h01;
			end else if (fix_r != 8'h00) begin
				fix_r <= fix_r - 8'h01;
				o_fix_done <= (fix_r == 8'h01);
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the mode-control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        i_clk, i_arst_n, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, q;
	logic        o_pready, o_pslverr, err;
	logic        i_parity_err, i_fifo_avail, i_fifo_half_full;
	logic        i_fmt_page_done, i_fmt_ce, i_fmt_uce, i_fmt_te, i_fmt_fix_done;
	logic        o_fmt_start, o_fmt_correct, o_fmt_xfer, o_fmt_stop;
	logic [1:0]  o_xfer_mode;
	logic        o_read_rate_select, o_transfer_request_pin, o_irq;
	logic [3:0]  pages;
	logic [2:0]  flags;
	logic [7:0]  gap;
	int          bad_count, n_checks, n_xfer, n_corr, n_stop;
	bem_mode_ctrl i_dut (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_parity_err, .i_fifo_avail, .i_fifo_half_full,
		.i_fmt_page_done, .i_fmt_ce, .i_fmt_uce, .i_fmt_te, .i_fmt_fix_done, .o_fmt_start,
		.o_fmt_correct, .o_fmt_xfer, .o_fmt_stop, .o_xfer_mode, .o_read_rate_select,
		.o_transfer_request_pin, .o_irq);
	bem_fmt_model i_fmt (.i_clk(i_clk), .i_rst_n(i_arst_n), .i_start(o_fmt_start),
		.i_correct(o_fmt_correct), .i_stop(o_fmt_stop), .i_pages(pages), .i_flags(flags),
		.i_gap(gap), .o_page_done(i_fmt_page_done), .o_ce(i_fmt_ce), .o_uce(i_fmt_uce),
		.o_te(i_fmt_te), .o_fix_done(i_fmt_fix_done));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		n_xfer += (o_fmt_xfer === 1'b1);
		n_corr += (o_fmt_correct === 1'b1);
		n_stop += (o_fmt_stop === 1'b1);
	end
	task automatic report_and_stop;
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask
	// apb master: hold the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		if (o_pready !== 1'b1) begin
			chk(0, 1, "pready timeout");
			report_and_stop;
		end
		q = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic settle;
		repeat (3) @(posedge i_clk);
	endtask
	// bounded poll of the busy bit
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			rd(bem_pkg::OFS_STATUS);
			n++;
		end while (q[bem_pkg::ST_BUSY] !== 1'b0 && n < 100);
		if (q[bem_pkg::ST_BUSY] !== 1'b0) begin
			chk(0, 1, "busy timeout");
			report_and_stop;
		end
		settle;
	endtask
	task automatic cmd(input logic [3:0] c);
		wr(bem_pkg::OFS_CMD, {28'h0, c});
	endtask
	initial begin
		logic [7:0] en_t [3];
		int m, e, k, i;
		logic halted, ex, adv, irq_x;
		en_t = '{8'h00, 8'h01, 8'h18};
		{i_arst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		{i_parity_err, i_fifo_avail, i_fifo_half_full, flags} = '0;
		pages = 4'h1;
		gap = 8'h03;
		{bad_count, n_checks, n_xfer, n_corr, n_stop} = '0;
		repeat (10) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (5) @(posedge i_clk);
		rd(bem_pkg::OFS_ENABLE);
		chk(q, {24'h0, bem_pkg::ENABLE_RST}, "enable reset");
		rd(bem_pkg::OFS_ADDR);
		chk(q, {21'h0, bem_pkg::ADDR_RST}, "address reset");
		rd(bem_pkg::OFS_BLEN);
		chk(q, {21'h0, bem_pkg::BLEN_RST}, "length reset");
		rd(8'h14);
		chk({31'h0, err}, 1, "unmapped error");
		i_fifo_avail <= 1'b1;
		wr(bem_pkg::OFS_STATUS, 32'hFF);
		rd(bem_pkg::OFS_STATUS);
		chk(q, 32'h01, "status read only, fifo bit live");
		i_fifo_avail <= 1'b0;
		for (i = 0; i < 3; i++) begin
			i_fifo_half_full <= i[0];
			wr(bem_pkg::OFS_ENABLE, {24'h0, en_t[i]});
			settle;
			chk(o_xfer_mode, i, "transfer mode");
			chk(o_read_rate_select, i == 2, "rate select");
			chk(o_transfer_request_pin, i[0], "half-full pin");
		end
		rd(bem_pkg::OFS_ENABLE);
		chk(q, 32'h18, "enable readback");
		wr(bem_pkg::OFS_ENABLE, 32'h01);
		cmd(bem_pkg::CMD_INIT);
		wait_idle;
		chk(o_irq, 1, "completion irq");
		wr(bem_pkg::OFS_ENABLE, 32'h00);
		settle;
		chk(o_irq, 0, "completion irq off live");
		wr(bem_pkg::OFS_ENABLE, 32'h02);
		cmd(bem_pkg::CMD_INIT);
		wait_idle;
		i_parity_err <= 1'b1;
		@(posedge i_clk);
		i_parity_err <= 1'b0;
		settle;
		chk(o_irq, 1, "parity irq");
		rd(bem_pkg::OFS_STATUS);
		chk(q[bem_pkg::ST_PAR], 1, "parity status");
		wr(bem_pkg::OFS_ENABLE, 32'h00);
		cmd(bem_pkg::CMD_INIT);
		wait_idle;
		gap <= 8'h3C;
		cmd(bem_pkg::CMD_READ);
		cmd(bem_pkg::CMD_INIT);
		rd(bem_pkg::OFS_STATUS);
		chk(q[7:6], 2'b10, "command ignored while busy");
		n_stop = 0;
		cmd(bem_pkg::CMD_ABORT);
		wait_idle;
		chk(n_stop, 1, "abort while busy");
		gap <= 8'h03;
		wr(bem_pkg::OFS_ADDR, 32'h5);
		wr(bem_pkg::OFS_BLEN, 32'h2);
		pages <= 4'h2;
		n_xfer = 0;
		cmd(bem_pkg::CMD_READ);
		wait_idle;
		rd(bem_pkg::OFS_ADDR);
		chk(q, 32'h7, "address after good block");
		chk(n_xfer, 2, "pages moved");
		// a write block walks the same page sequence from where the read stopped
		n_xfer = 0;
		cmd(bem_pkg::CMD_WRITE);
		wait_idle;
		rd(bem_pkg::OFS_ADDR);
		chk(q, 32'h9, "address after write block");
		chk(n_xfer, 2, "pages written");
		wr(bem_pkg::OFS_BLEN, 32'h1);
		pages <= 4'h1;
		// mode x error bit x error kind; mode 3 sets both correction bits, an unused setting
		for (m = 0; m < 4; m++) for (e = 0; e < 2; e++) for (k = 0; k < 3; k++) begin
			wr(bem_pkg::OFS_ENABLE, {25'h0, m[0], m[1], 5'h0} | (e ? 32'h4 : 32'h0));
			cmd(bem_pkg::CMD_INIT);
			wait_idle;
			wr(bem_pkg::OFS_ADDR, 32'h10);
			flags <= 3'h1 << k;
			n_xfer = 0;
			n_corr = 0;
			cmd(bem_pkg::CMD_READ);
			wait_idle;
			flags <= 3'h0;
			halted = (m == 2) && (k != 0 || e == 1);
			ex = (m == 2) ? !halted : (k != 2);
			adv = (m == 2) ? !halted : (m == 0) ? (k != 2) : (k == 0);
			irq_x = (m == 0) ? (e == 1 && k == 2) : (m != 3) && (e == 1 || k != 0);
			chk(o_irq, irq_x, "error irq");
			rd(bem_pkg::OFS_ADDR);
			chk(n_xfer, ex, "page to fifo");
			chk(q, 32'h10 + adv, "address advance");
			if (k == 0 && m != 0 && !halted)
				chk(n_corr != 0, 1, "correction issued");
			if (k == 0 && m == 1 && e == 0) begin
				rd(bem_pkg::OFS_STATUS);
				chk(q[bem_pkg::ST_CE], 1, "corrected error reported");
			end
			if (m == 1 && k == 1) begin
				cmd(bem_pkg::CMD_READ);
				wait_idle;
				rd(bem_pkg::OFS_ADDR);
				chk(q, 32'h11, "retry delivers failed page");
			end
			if (halted && k == 0) begin
				n_corr = 0;
				cmd(bem_pkg::CMD_RCORR);
				repeat (10) @(posedge i_clk);
				wait_idle;
				chk(q[bem_pkg::ST_DONE], 1, "held page corrected");
				chk(n_corr, 1, "held page correct request");
			end
			cmd(bem_pkg::CMD_ABORT);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
